/* File: rtl/agp_gpio.sv */
// Auto-direction pin block: latches, directions, queries and byte ports
// Contract
// - On drives latch high, off drives low
// - Set: zero gives low, nonzero high
// - Toggle inverts the latch
// - Latch query returns last written value
// - Level query returns real pin level, both senses
// - Level query turns pin into input
// - Latch query leaves direction alone
// - Any output operation turns pin into output
// - Pulse outputs fixed output, no level reads
// - Fourteen input-only pins, no drive
// - Indicator pins output-only, not readable inputs
// - Port bit 0 is LSB, bit 7 MSB
// - Port read returns byte, all pins input
// - Port write loads byte, all pins output
// - Serial channel pins excluded from pin map
// - Timer pins double as general-purpose bits
`timescale 1ns/100ps
`default_nettype none
module agp_gpio (
  // Clock and reset
  input  wire logic                            clk_sys_i,
  input  wire logic                            sys_rst_i,
  // APB slave
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [11:0]                     paddr_i,
  input  wire logic [31:0]                     pwdata_i,
  output logic      [31:0]                     prdata_o,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  // Two-way pins, ports first then spare bits then timer pins
  input  wire logic [agp_pkg::NUM_BIDIR-1:0]  bidir_in_i,
  output logic      [agp_pkg::NUM_BIDIR-1:0]  bidir_out_o,
  output logic      [agp_pkg::NUM_BIDIR-1:0]  bidir_oe_o,
  // Output-only pins
  output logic      [agp_pkg::NUM_LED-1:0]    led_o,
  output logic      [agp_pkg::NUM_PWM-1:0]    pwm_o,
  // Input-only pins
  input  wire logic [agp_pkg::NUM_INONLY-1:0] inonly_i,
  // Timer pin levels for the alternate function
  output logic      [agp_pkg::NUM_TIMER-1:0]  timer_level_o
);
  localparam int NB = agp_pkg::NUM_BIDIR;   // Two-way pin count
  localparam int ND = agp_pkg::NUM_DRIVEN;  // Latched pin count
  localparam int NS = agp_pkg::NUM_SENSED;  // Sensed pin count
  localparam int PW = agp_pkg::PORT_W;      // Port width

  // Pin map must hold both ports and the timer pins
  if (NB < 2 * PW || NB < int'(agp_pkg::TIMER_BASE) + agp_pkg::NUM_TIMER
      || ND > 64 || NB > 64) begin : g_chk
    $error("agp_gpio pin map does not fit its registers");
  end

  agp_reg_if           rbus ();   // Strobes from the bus front end
  logic [NS-1:0]       lvl_sync;  // Synchronised levels, two-way then input-only
  logic [ND-1:0]       latch_q;   // Output latches
  logic [NB-1:0]       dir_q;     // One means output
  logic [31:0]         result_q;  // Answer to the last command
  logic                cmd_go;    // Command write this edge
  logic [6:0]          cmd_pin;   // Addressed pin
  agp_pkg::agp_op_e    cmd_op;    // Requested operation
  agp_pkg::agp_kind_e  cmd_kind;  // Capability of that pin
  logic                cmd_val;   // Set value is nonzero
  logic                op_out;    // Operation drives the latch
  logic                op_ok;     // Operation allowed on this pin
  logic                new_bit;   // Latch value an output operation writes
  logic                lvl_bit;   // Level of the addressed pin
  logic                lat_bit;   // Latch of the addressed pin
  logic [6:0]          in_idx;    // Offset within the input-only group
  logic                pa_wr;     // First port write
  logic                pb_wr;     // Second port write
  logic                pa_rd;     // First port read
  logic                pb_rd;     // Second port read

  // Bus front end
  agp_apb_front u_front (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .bus       (rbus)
  );

  // Pins come from outside the clock domain
  agp_sync #(.WIDTH(NS)) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({inonly_i, bidir_in_i}),
    .sync_o    (lvl_sync)
  );

  // Command decode from the write word
  assign cmd_go   = rbus.wr_stb && (rbus.addr == agp_pkg::OFF_CMD);
  assign cmd_pin  = rbus.wdata[agp_pkg::CMD_PIN_LSB +: 7];
  assign cmd_op   = agp_pkg::agp_op_e'(rbus.wdata[agp_pkg::CMD_OP_LSB +: 3]);
  assign cmd_kind = agp_pkg::agp_pin_kind(cmd_pin);
  assign cmd_val  = |rbus.wdata[31:agp_pkg::CMD_VAL_LSB];
  assign in_idx   = cmd_pin - agp_pkg::INONLY_BASE;

  // Byte port strobes; a read acts at the access edge only
  assign pa_wr = rbus.wr_stb && (rbus.addr == agp_pkg::OFF_PORT_FIRST);
  assign pb_wr = rbus.wr_stb && (rbus.addr == agp_pkg::OFF_PORT_SECOND);
  assign pa_rd = rbus.rd_stb && (rbus.addr == agp_pkg::OFF_PORT_FIRST);
  assign pb_rd = rbus.rd_stb && (rbus.addr == agp_pkg::OFF_PORT_SECOND);

  // Classify the operation against the pin's abilities
  always_comb begin
    op_out  = 1'b0;
    op_ok   = 1'b0;
    new_bit = 1'b0;
    lvl_bit = 1'b0;
    lat_bit = 1'b0;
    // Pin levels and latches seen by queries
    if (cmd_kind == agp_pkg::KIND_BIDIR) begin
      lvl_bit = lvl_sync[cmd_pin[5:0]];
    end else if (cmd_kind == agp_pkg::KIND_IN) begin
      lvl_bit = lvl_sync[NB + int'(in_idx[3:0])];
    end
    if (cmd_kind == agp_pkg::KIND_BIDIR || cmd_kind == agp_pkg::KIND_OUT) begin
      lat_bit = latch_q[cmd_pin[5:0]];
    end
    // Latch bit also feeds toggle, so software needs no read-back
    case (cmd_op)
      agp_pkg::OP_ON: begin
        op_out  = 1'b1;
        new_bit = 1'b1;
      end
      agp_pkg::OP_OFF: begin
        op_out  = 1'b1;
        new_bit = 1'b0;
      end
      agp_pkg::OP_SET: begin
        op_out  = 1'b1;
        new_bit = cmd_val;
      end
      agp_pkg::OP_TOGGLE: begin
        op_out  = 1'b1;
        new_bit = ~lat_bit;
      end
      default: begin
        op_out  = 1'b0;
        new_bit = 1'b0;
      end
    endcase
    // Input-only pins take no drive; output-only take no level read
    case (cmd_op)
      agp_pkg::OP_ON, agp_pkg::OP_OFF, agp_pkg::OP_SET, agp_pkg::OP_TOGGLE,
      agp_pkg::OP_LATCH: begin
        op_ok = (cmd_kind == agp_pkg::KIND_BIDIR)
             || (cmd_kind == agp_pkg::KIND_OUT);
      end
      agp_pkg::OP_LEVEL: begin
        op_ok = (cmd_kind == agp_pkg::KIND_BIDIR)
             || (cmd_kind == agp_pkg::KIND_IN);
      end
      default: begin
        op_ok = 1'b0;  // Unused operation codes
      end
    endcase
  end

  // Output latches; kept while a pin is an input
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      latch_q <= agp_pkg::LATCH_RST;
    end else begin
      // Refused operations never touch a latch
      if (cmd_go && op_out && op_ok) begin
        latch_q[cmd_pin[5:0]] <= new_bit;
      end
      // Bit 0 of the byte lands on pin 0 of the port
      if (pa_wr) begin
        latch_q[agp_pkg::FIRST_PORT_BASE[5:0] +: PW] <= rbus.wdata[PW-1:0];
      end
      if (pb_wr) begin
        latch_q[agp_pkg::SECOND_PORT_BASE[5:0] +: PW] <= rbus.wdata[PW-1:0];
      end
    end
  end

  // Directions: only two-way pins have one
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dir_q <= agp_pkg::DIR_RST;
    end else begin
      if (cmd_go && cmd_kind == agp_pkg::KIND_BIDIR) begin
        if (op_out) begin
          dir_q[cmd_pin[5:0]] <= 1'b1;
        end else if (cmd_op == agp_pkg::OP_LEVEL) begin
          dir_q[cmd_pin[5:0]] <= 1'b0;
        end
        // Latch query and bad codes keep the direction
      end
      // One transfer at a time, so port strobes never meet a command
      if (pa_wr) begin
        dir_q[agp_pkg::FIRST_PORT_BASE[5:0] +: PW] <= '1;
      end else if (pa_rd) begin
        dir_q[agp_pkg::FIRST_PORT_BASE[5:0] +: PW] <= '0;
      end
      if (pb_wr) begin
        dir_q[agp_pkg::SECOND_PORT_BASE[5:0] +: PW] <= '1;
      end else if (pb_rd) begin
        dir_q[agp_pkg::SECOND_PORT_BASE[5:0] +: PW] <= '0;
      end
    end
  end

  // Result word: both senses of the answer plus an error flag
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_q <= agp_pkg::RESULT_RST;
    end else if (cmd_go) begin
      result_q <= '0;
      // Refused commands leave both sense bits clear
      result_q[agp_pkg::RES_ERR_BIT] <= ~op_ok;
      if (op_ok) begin
        if (cmd_op == agp_pkg::OP_LEVEL) begin
          // Level sampled before the pin turns; a pin just released
          // may still show the value it drove
          result_q[agp_pkg::RES_HIGH_BIT] <= lvl_bit;
          result_q[agp_pkg::RES_LOW_BIT]  <= ~lvl_bit;
        end else if (cmd_op == agp_pkg::OP_LATCH) begin
          result_q[agp_pkg::RES_HIGH_BIT] <= lat_bit;
          result_q[agp_pkg::RES_LOW_BIT]  <= ~lat_bit;
        end else begin
          result_q[agp_pkg::RES_HIGH_BIT] <= new_bit;
          result_q[agp_pkg::RES_LOW_BIT]  <= ~new_bit;
        end
      end
    end
  end

  // Read mux; the front end registers it in the setup cycle
  always_comb begin
    rbus.rdata = 32'h0000_0000;
    rbus.err   = 1'b0;
    // Upper words read as zero above the last pin
    case (rbus.addr)
      agp_pkg::OFF_CMD:         rbus.rdata = 32'h0000_0000;  // Write-only
      agp_pkg::OFF_RESULT:      rbus.rdata = result_q;
      agp_pkg::OFF_PORT_FIRST:
        rbus.rdata[PW-1:0] = lvl_sync[agp_pkg::FIRST_PORT_BASE[5:0] +: PW];
      agp_pkg::OFF_PORT_SECOND:
        rbus.rdata[PW-1:0] = lvl_sync[agp_pkg::SECOND_PORT_BASE[5:0] +: PW];
      agp_pkg::OFF_DIR_LO:      rbus.rdata = dir_q[31:0];
      agp_pkg::OFF_DIR_HI:      rbus.rdata[NB-33:0] = dir_q[NB-1:32];
      agp_pkg::OFF_INONLY:      rbus.rdata[agp_pkg::NUM_INONLY-1:0] = lvl_sync[NS-1:NB];
      agp_pkg::OFF_LATCH_LO:    rbus.rdata = latch_q[31:0];
      agp_pkg::OFF_LATCH_HI:    rbus.rdata[ND-33:0] = latch_q[ND-1:32];
      default:                  rbus.err = 1'b1;  // Unmapped answers error
    endcase
  end

  // Pin drivers; serial pins have no index and never appear here
  assign bidir_out_o   = latch_q[NB-1:0];
  assign bidir_oe_o    = dir_q;
  assign led_o         = latch_q[agp_pkg::LED_BASE[5:0] +: agp_pkg::NUM_LED];
  assign pwm_o         = latch_q[agp_pkg::PWM_BASE[5:0] +: agp_pkg::NUM_PWM];
  // Timer pins keep serving their timer while also being plain bits
  assign timer_level_o = lvl_sync[agp_pkg::TIMER_BASE[5:0] +: agp_pkg::NUM_TIMER];

  // Checks on the command path
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  logic good_bidir;  // Command on a two-way pin that is allowed
  assign good_bidir = cmd_go && op_ok && cmd_kind == agp_pkg::KIND_BIDIR;

  // Port write followed by a port read on the first port
  sequence s_pa_write;
    pa_wr ##1 1'b1;
  endsequence
  sequence s_pa_then_read;
    s_pa_write ##[0:20] pa_rd;
  endsequence

  // Output operations land in the latch
  a_on_high: assert property ((cmd_go && op_ok && cmd_op == agp_pkg::OP_ON) |=>
    latch_q[$past(cmd_pin[5:0])]) else $error("on left latch low");
  a_off_low: assert property ((cmd_go && op_ok && cmd_op == agp_pkg::OP_OFF) |=>
    !latch_q[$past(cmd_pin[5:0])]) else $error("off left latch high");
  a_set_value: assert property ((cmd_go && op_ok && cmd_op == agp_pkg::OP_SET) |=>
    latch_q[$past(cmd_pin[5:0])] == (|$past(rbus.wdata[31:12])))
    else $error("set value not applied");
  a_toggle_flip: assert property ((cmd_go && op_ok && cmd_op == agp_pkg::OP_TOGGLE
    && !pa_wr && !pb_wr) |=> latch_q[$past(cmd_pin[5:0])] != $past(lat_bit))
    else $error("toggle did not invert");

  // Queries answer in both senses
  a_latch_answer: assert property ((cmd_go && op_ok && cmd_op == agp_pkg::OP_LATCH) |=>
    result_q[1:0] == {~$past(lat_bit), $past(lat_bit)}) else $error("latch answer wrong");
  a_level_answer: assert property ((cmd_go && op_ok && cmd_op == agp_pkg::OP_LEVEL) |=>
    result_q[1:0] == {~$past(lvl_bit), $past(lvl_bit)}) else $error("level answer wrong");
  a_level_input: assert property ((good_bidir && cmd_op == agp_pkg::OP_LEVEL
    && !rbus.addr[3]) |=> !bidir_oe_o[$past(cmd_pin[5:0])]) else $error("level kept output");
  a_latch_dir: assert property ((good_bidir && cmd_op == agp_pkg::OP_LATCH) |=>
    dir_q == $past(dir_q)) else $error("latch query moved direction");
  a_out_dir: assert property ((good_bidir && op_out) |=>
    dir_q[$past(cmd_pin[5:0])]) else $error("output op left pin input");
  a_outonly_level: assert property ((cmd_go && cmd_op == agp_pkg::OP_LEVEL
    && cmd_kind == agp_pkg::KIND_OUT) |=> result_q[31]) else $error("level read on output pin");
  a_inonly_drive: assert property ((cmd_go && op_out && cmd_kind == agp_pkg::KIND_IN)
    |=> result_q[31] && latch_q == $past(latch_q)) else $error("input-only pin driven");

  // First port byte access
  a_port_write: assert property (pa_wr |=> bidir_oe_o[7:0] == 8'hFF
    && bidir_out_o[7:0] == $past(rbus.wdata[7:0])) else $error("port write wrong");
  a_port_read: assert property (s_pa_then_read |=> bidir_oe_o[7:0] == 8'h00)
    else $error("port read kept outputs");
  a_latch_keep: assert property ((good_bidir && cmd_op == agp_pkg::OP_LEVEL) |=>
    latch_q == $past(latch_q)) else $error("level read moved a latch");

  // Second port mirrors the first
  a_port2_write: assert property (pb_wr |=> bidir_oe_o[15:8] == 8'hFF
    && bidir_out_o[15:8] == $past(rbus.wdata[7:0])) else $error("port two write wrong");
  a_port2_read: assert property (pb_rd |=> bidir_oe_o[15:8] == 8'h00)
    else $error("port two read kept outputs");

  // A refused command reports an error and changes nothing
  a_refused_keep: assert property ((cmd_go && !op_ok) |=>
    result_q[31] && result_q[1:0] == 2'b00 && latch_q == $past(latch_q)
    && dir_q == $past(dir_q)) else $error("refused command changed state");

  // With no strobe, directions and latches hold
  a_dir_hold: assert property (!(cmd_go || pa_wr || pb_wr || pa_rd || pb_rd) |=>
    dir_q == $past(dir_q)) else $error("direction moved without a strobe");
  a_latch_hold: assert property (!(cmd_go || pa_wr || pb_wr) |=>
    latch_q == $past(latch_q)) else $error("latch moved without a strobe");

endmodule : agp_gpio
`default_nettype wire

/* File: rtl/agp_pkg.sv */
// Package for the auto-direction pin block: pin map, register map, commands
package agp_pkg;

  // Pin groups, counted from pin index zero upward
  localparam int NUM_BIDIR   = 42;  // Two-way pins under software direction
  localparam int NUM_LED     = 3;   // Indicator outputs
  localparam int NUM_PWM     = 12;  // Pulse outputs, fixed as outputs
  localparam int NUM_INONLY  = 14;  // Current-sense and fault inputs
  localparam int NUM_TIMER   = 14;  // Timer and decoder pins among the two-way pins
  localparam int PORT_W      = 8;   // Width of each byte-wide port
  localparam int NUM_DRIVEN  = NUM_BIDIR + NUM_LED + NUM_PWM;
  localparam int NUM_SENSED  = NUM_BIDIR + NUM_INONLY;

  // Pin index positions in the command pin field
  localparam logic [6:0] FIRST_PORT_BASE  = 7'h00;
  localparam logic [6:0] SECOND_PORT_BASE = 7'h08;
  localparam logic [6:0] TIMER_BASE       = 7'h1C;
  localparam logic [6:0] LED_BASE         = 7'(NUM_BIDIR);
  localparam logic [6:0] PWM_BASE         = 7'(NUM_BIDIR + NUM_LED);
  localparam logic [6:0] INONLY_BASE      = 7'(NUM_DRIVEN);
  localparam logic [6:0] PIN_END          = 7'(NUM_DRIVEN + NUM_INONLY);

  // Register byte offsets
  localparam logic [11:0] OFF_CMD         = 12'h000;
  localparam logic [11:0] OFF_RESULT      = 12'h004;
  localparam logic [11:0] OFF_PORT_FIRST  = 12'h008;
  localparam logic [11:0] OFF_PORT_SECOND = 12'h00C;
  localparam logic [11:0] OFF_DIR_LO      = 12'h010;
  localparam logic [11:0] OFF_DIR_HI      = 12'h014;
  localparam logic [11:0] OFF_INONLY      = 12'h018;
  localparam logic [11:0] OFF_LATCH_LO    = 12'h01C;
  localparam logic [11:0] OFF_LATCH_HI    = 12'h020;

  // Command word fields
  localparam int CMD_PIN_LSB = 0;
  localparam int CMD_OP_LSB  = 8;
  localparam int CMD_VAL_LSB = 12;

  // Result word fields
  localparam int RES_HIGH_BIT = 0;
  localparam int RES_LOW_BIT  = 1;
  localparam int RES_ERR_BIT  = 31;

  // Reset values: every two-way pin an input, every latch low
  localparam logic [NUM_BIDIR-1:0]  DIR_RST    = '0;
  localparam logic [NUM_DRIVEN-1:0] LATCH_RST  = '0;
  localparam logic [31:0]           RESULT_RST = 32'h0000_0000;

  // Pin operations carried in the command word
  typedef enum logic [2:0] {
    OP_ON, OP_OFF, OP_SET, OP_TOGGLE, OP_LEVEL, OP_LATCH
  } agp_op_e;

  // What a pin index can do
  typedef enum logic [1:0] {
    KIND_BIDIR, KIND_OUT, KIND_IN, KIND_NONE
  } agp_kind_e;

  // Classify a pin index; serial pins have no index at all
  function automatic agp_kind_e agp_pin_kind(input logic [6:0] pin);
    if (pin < LED_BASE) return KIND_BIDIR;
    if (pin < INONLY_BASE) return KIND_OUT;
    if (pin < PIN_END) return KIND_IN;
    return KIND_NONE;
  endfunction : agp_pin_kind

endpackage : agp_pkg

/* File: rtl/agp_reg_if.sv */
// Register strobe carrier between the bus front end and the pin core
`timescale 1ns/100ps
`default_nettype none
interface agp_reg_if;
  logic        wr_stb;  // Write takes effect this edge
  logic        rd_stb;  // Read completes this edge
  logic [11:0] addr;    // Byte address
  logic [31:0] wdata;   // Write data
  logic [31:0] rdata;   // Read data from the core
  logic        err;     // Address not mapped

  // Front end drives strobes, core answers
  modport front (output wr_stb, rd_stb, addr, wdata, input rdata, err);
  modport core  (input wr_stb, rd_stb, addr, wdata, output rdata, err);
endinterface : agp_reg_if
`default_nettype wire

/* File: rtl/agp_sync.sv */
// Two-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module agp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // Levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;  // First stage, read only by the second

  // Refuse a zero-width bank
  if (WIDTH < 1) begin : g_chk
    $error("agp_sync width must be at least one");
  end

  // Both stages clear to low
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : agp_sync
`default_nettype wire

/* File: rtl/agp_apb_front.sv */
// APB slave front end: zero-wait access, registered read data
`timescale 1ns/100ps
`default_nettype none
module agp_apb_front (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Core side
  agp_reg_if.front         bus
);
  // Address and data pass straight through; master holds them stable
  assign bus.addr  = paddr_i;
  assign bus.wdata = pwdata_i;
  // Strobes only at the access edge, so side effects fire once
  assign bus.wr_stb = psel_i & penable_i & pwrite_i;
  assign bus.rd_stb = psel_i & penable_i & ~pwrite_i;
  // Never stalls
  assign pready_o  = 1'b1;
  // Unmapped addresses answer with an error in the access phase
  assign pslverr_o = psel_i & penable_i & bus.err;

  // Capture read data in the setup cycle so it comes from a flop
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= bus.rdata;
    end
  end
endmodule : agp_apb_front
`default_nettype wire

/* File: bench/agp_pins_model.sv */
// Board-side model: outside circuits and the wiring of each pin
`timescale 1ns/100ps
`default_nettype none
module agp_pins_model (
  // Design side
  input  wire logic [41:0] bidir_out_i,
  input  wire logic [41:0] bidir_oe_i,
  // Levels the outside circuits apply
  input  wire logic [41:0] ext_lvl_i,
  input  wire logic [13:0] ext_in_i,
  // Levels seen at the pins
  output logic      [41:0] bidir_in_o,
  output logic      [13:0] inonly_o
);
  // Outside circuits are weak, so a driving pin wins over them
  assign bidir_in_o = (bidir_oe_i & bidir_out_i) | (~bidir_oe_i & ext_lvl_i);
  // Input-only pins follow the outside circuits directly
  assign inonly_o = ext_in_i;
endmodule : agp_pins_model
`default_nettype wire

/* File: bench/agp_gpio_tb.sv */
// Self-checking bench for the auto-direction pin block
`timescale 1ns/100ps
`default_nettype none
module agp_gpio_tb;
  logic        clk_sys_i;    // System clock
  logic        sys_rst_i;    // Async reset
  logic        psel;         // Bus request lines
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;       // Bus answer lines
  logic        pready;
  logic        pslverr;
  logic [41:0] pin_in;       // Pin wiring
  logic [41:0] pin_out;
  logic [41:0] pin_oe;
  logic [2:0]  led;
  logic [11:0] pwm;
  logic [13:0] in_lvl;
  logic [13:0] timer_lvl;
  logic [41:0] ext_lvl;      // Outside circuit levels
  logic [13:0] ext_in;
  logic [31:0] rd;           // Last read data
  logic        er;           // Last error response
  int          errors      = 0;
  int          check_count = 0;
  int          cycles      = 0;
  // Refused cases: pin and operation
  logic [6:0]  bad_pin [5] = '{7'h2A, 7'h2D, 7'h39, 7'h47, 7'h14};
  logic [2:0]  bad_op  [5] = '{3'h4, 3'h4, 3'h0, 3'h0, 3'h6};

  agp_gpio i_agp_gpio (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .bidir_in_i(pin_in),
    .bidir_out_o(pin_out), .bidir_oe_o(pin_oe), .led_o(led), .pwm_o(pwm),
    .inonly_i(in_lvl), .timer_level_o(timer_lvl));
  agp_pins_model i_agp_pins_model (.bidir_out_i(pin_out), .bidir_oe_i(pin_oe),
    .ext_lvl_i(ext_lvl), .ext_in_i(ext_in), .bidir_in_o(pin_in), .inonly_o(in_lvl));

  // Clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard, far above the couple of hundred cycles the tests need
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  // Compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One bus transfer; idle cycle first so no line is driven twice in a step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) begin
      @(posedge clk_sys_i);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Pin command followed by a result read
  task automatic cmd(input logic [6:0] pin, input logic [2:0] op, input logic [19:0] v);
    xfer(1'b1, agp_pkg::OFF_CMD, {v, 1'b0, op, 1'b0, pin});
    xfer(1'b0, agp_pkg::OFF_RESULT, 32'h0000_0000);
  endtask : cmd

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0000_0000;
    ext_lvl   = 42'h000_0000_A500;
    ext_in    = 14'h02A5;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    xfer(1'b0, agp_pkg::OFF_DIR_LO, 32'h0000_0000);
    chk("dir_lo reset", 32'h0000_0000, rd);
    $display("test reset done");
    // Output operations on a spare two-way pin
    cmd(7'h14, agp_pkg::OP_ON, 20'h00000);
    chk("on result", 32'h0000_0001, rd);
    chk("on oe", 32'h0000_0001, 32'(pin_oe[20]));
    cmd(7'h14, agp_pkg::OP_OFF, 20'h00000);
    chk("off pin", 32'h0000_0000, 32'(pin_out[20]));
    cmd(7'h14, agp_pkg::OP_TOGGLE, 20'h00000);
    chk("toggle result", 32'h0000_0001, rd);
    cmd(7'h14, agp_pkg::OP_SET, 20'h00000);
    chk("set zero", 32'h0000_0002, rd);
    cmd(7'h14, agp_pkg::OP_SET, 20'h80000);
    chk("set nonzero", 32'h0000_0001, 32'(pin_out[20]));
    cmd(7'h14, agp_pkg::OP_LATCH, 20'h00000);
    chk("latch query", 32'h0000_0001, rd);
    chk("latch query oe", 32'h0000_0001, 32'(pin_oe[20]));
    $display("test output ops done");
    // Level queries: first one releases the pin, later ones see the outside level
    cmd(7'h14, agp_pkg::OP_LEVEL, 20'h00000);
    chk("level query oe", 32'h0000_0000, 32'(pin_oe[20]));
    repeat (4) @(posedge clk_sys_i);
    cmd(7'h14, agp_pkg::OP_LEVEL, 20'h00000);
    chk("level low", 32'h0000_0002, rd);
    ext_lvl[20] <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    cmd(7'h14, agp_pkg::OP_LEVEL, 20'h00000);
    chk("level high", 32'h0000_0001, rd);
    xfer(1'b0, agp_pkg::OFF_LATCH_LO, 32'h0000_0000);
    chk("latch kept", 32'h0000_0001, 32'(rd[20]));
    $display("test level query done");
    // Timer pin as plain bit, LED, pulse and input-only pins
    cmd(7'h1C, agp_pkg::OP_ON, 20'h00000);
    repeat (3) @(posedge clk_sys_i);
    chk("timer level", 32'h0000_0001, 32'(timer_lvl[0]));
    cmd(7'h2A, agp_pkg::OP_ON, 20'h00000);
    chk("led on", 32'h0000_0001, 32'(led[0]));
    cmd(7'h38, agp_pkg::OP_SET, 20'h00001);
    chk("pulse set", 32'h0000_0001, 32'(pwm[11]));
    xfer(1'b0, agp_pkg::OFF_LATCH_HI, 32'h0000_0000);
    chk("latch_hi", 32'h0100_0400, rd);
    cmd(7'h39, agp_pkg::OP_LEVEL, 20'h00000);
    chk("input-only level", 32'h0000_0001, rd);
    xfer(1'b0, agp_pkg::OFF_INONLY, 32'h0000_0000);
    chk("input-only reg", 32'h0000_02A5, rd);
    for (int i = 0; i < 5; i++) begin
      cmd(bad_pin[i], bad_op[i], 20'h00001);
      chk("refused op", 32'h8000_0000, rd);
    end
    $display("test pin kinds done");
    // Byte ports
    xfer(1'b1, agp_pkg::OFF_PORT_FIRST, 32'h0000_0080);
    @(posedge clk_sys_i);
    chk("port write pins", 32'h0000_0080, 32'(pin_out[7:0]));
    chk("port write oe", 32'h0000_00FF, 32'(pin_oe[7:0]));
    xfer(1'b0, agp_pkg::OFF_PORT_FIRST, 32'h0000_0000);
    chk("port1 read data", 32'h0000_0080, rd);
    @(posedge clk_sys_i);
    chk("port1 read oe", 32'h0000_0000, 32'(pin_oe[7:0]));
    xfer(1'b1, agp_pkg::OFF_PORT_SECOND, 32'h0000_003C);
    xfer(1'b0, agp_pkg::OFF_PORT_SECOND, 32'h0000_0000);
    repeat (3) @(posedge clk_sys_i);
    chk("port read oe", 32'h0000_0000, 32'(pin_oe[15:8]));
    xfer(1'b0, agp_pkg::OFF_PORT_SECOND, 32'h0000_0000);
    chk("port read data", 32'h0000_00A5, rd);
    xfer(1'b0, 12'h024, 32'h0000_0000);
    chk("unmapped data", 32'h0000_0000, rd);
    chk("unmapped err", 32'h0000_0001, 32'(er));
    chk("ready", 32'h0000_0001, 32'(pready));
    $display("test byte ports done");
    close_out();
  end
endmodule : agp_gpio_tb
`default_nettype wire
